// ==== pkg/crn_params.svh ====
`ifndef CRN_PARAMS_SVH
`define CRN_PARAMS_SVH
// ==========================================
// Widths
`define CRN_ACC_W 32
`define CRN_STEPS_W 22
`define CRN_TIMING_W 2
// ==========================================
// Timing field codes
`define CRN_TIMING_NEXT_IE 2'h0
`define CRN_TIMING_IMMEDIATE 2'h1
`define CRN_TIMING_REPEAT_IE 2'h2
// ==========================================
// Reset values and other constants
`define CRN_ZERO32 32'h0000_0000
`define CRN_ZERO22 22'h00_0000
`define CRN_ONE22 22'h00_0001
`define CRN_MSB 31
// ==========================================
// Software port register indices
`define CRN_ADDR_W 3
`define CRN_REG_SW_RATE 3'h0
`define CRN_REG_ADJUST 3'h1
`define CRN_REG_SETTINGS 3'h2
`define CRN_REG_CODE_CTRL 3'h3
`define CRN_REG_PHASE_IE 3'h4
`define CRN_REG_PHASE_ME 3'h5
`define CRN_REG_STATUS 3'h6
`endif

// ==== pkg/crn_pkg.sv ====
package crn_pkg;
  // Adjustment sequencer states
  typedef enum logic [2:0] {
    CRN_IDLE = 3'b001,
    CRN_ARMED = 3'b010,
    CRN_APPLY = 3'b100
  } crn_adj_state_type;
endpackage

// ==== pkg/crn_link_if.sv ====
`timescale 1ns/1ps
interface crn_link_if;
  // Aiding unit to device
  logic [31:0] aided_rate_term;
  // Between device and code generator and integration counter, both directions
  logic rate_sin;
  logic rate_cos;
  logic integration_epoch;
  logic measurement_epoch;
  logic primary_chip;
  logic lfsr_chip;
  logic code_out1;
  logic code_out2;
  modport dev (
    input aided_rate_term, integration_epoch, measurement_epoch, primary_chip, lfsr_chip,
    output rate_sin, rate_cos, code_out1, code_out2
  );
  modport far (
    output aided_rate_term, integration_epoch, measurement_epoch, primary_chip, lfsr_chip,
    input rate_sin, rate_cos, code_out1, code_out2
  );
endinterface

// ==== core/crn_tdm_mux.sv ====
`timescale 1ns/1ps
`include "crn_params.svh"
// Two-code output stage: normal or time multiplexed
module crn_tdm_mux (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Control
  input wire logic time_multiplex_enable_in,
  input wire logic [1:0] subcarrier_pattern_in,
  input wire logic rate_sin_in,
  // Chips
  input wire logic lfsr_chip_in,
  input wire logic primary_chip_in,
  // Outputs
  output logic code_out1_out,
  output logic code_out2_out
);
  logic slot;
  // ==========================================
  // Slot toggles per subcarrier pulse
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      slot <= 1'b0;
    end else if (rate_sin_in) begin
      slot <= ~slot;
    end
  end
  // Subcarrier register bit for current slot
  logic sc_bit;
  assign sc_bit = subcarrier_pattern_in[slot];
  // ==========================================
  // Code outputs
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      code_out1_out <= 1'b0;
      code_out2_out <= 1'b0;
    end else if (time_multiplex_enable_in) begin
      code_out1_out <= slot ? primary_chip_in : lfsr_chip_in;
      code_out2_out <= sc_bit;
    end else begin
      code_out1_out <= lfsr_chip_in ^ sc_bit;
      code_out2_out <= primary_chip_in ^ sc_bit;
    end
  end
endmodule

// ==== core/crn_far_end.sv ====
`timescale 1ns/1ps
`include "crn_params.svh"
// Aiding unit term source and integration counter
module crn_far_end #(
  parameter int EPOCH_PULSES = 16
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // User side
  input wire logic [31:0] aided_rate_term_in,
  input wire logic measure_req_in,
  input wire logic lfsr_chip_in,
  input wire logic primary_chip_in,
  output logic code_out1_out,
  output logic code_out2_out,
  output logic integration_epoch_out,
  // Link
  crn_link_if.far link
);
  logic [15:0] count;
  logic ie;
  logic me;
  logic c1;
  logic c2;
  // ==========================================
  // Integration counter, advances only on subcarrier pulses
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= 16'h0000;
      ie <= 1'b0;
    end else begin
      ie <= 1'b0;
      if (link.rate_sin) begin
        if (count == 16'(EPOCH_PULSES - 1)) begin
          count <= 16'h0000;
          ie <= 1'b1;
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end
  // Registered outputs
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      me <= 1'b0;
      c1 <= 1'b0;
      c2 <= 1'b0;
      integration_epoch_out <= 1'b0;
      code_out1_out <= 1'b0;
      code_out2_out <= 1'b0;
    end else begin
      me <= measure_req_in;
      c1 <= lfsr_chip_in;
      c2 <= primary_chip_in;
      integration_epoch_out <= ie;
      code_out1_out <= link.code_out1;
      code_out2_out <= link.code_out2;
    end
  end
  assign link.aided_rate_term = aided_rate_term_in;
  assign link.integration_epoch = ie;
  assign link.measurement_epoch = me;
  assign link.lfsr_chip = c1;
  assign link.primary_chip = c2;
endmodule

// ==== core/crn_rate_gen.sv ====
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "crn_params.svh"
module crn_rate_gen (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Software port
  input wire logic [`CRN_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Link
  crn_link_if.dev link
);
  // ==========================================
  // Software registers
  logic [31:0] software_rate_term;
  logic signed [31:0] phase_adjust_value;
  logic [`CRN_STEPS_W-1:0] phase_adjust_repeat_count;
  logic [`CRN_TIMING_W-1:0] phase_adjust_timing;
  logic time_multiplex_enable;
  logic [1:0] subcarrier_pattern;
  logic [31:0] phase_at_integration;
  logic [31:0] phase_at_measurement;
  logic [31:0] code_rate_increment;
  logic [31:0] acc;
  logic cos_armed;
  logic [`CRN_STEPS_W-1:0] steps_left;
  crn_pkg::crn_adj_state_type state;
  logic adj_start;
  logic new_settings;
  logic pend_rate;
  logic [31:0] pend_rate_value;
  logic rate_sin;
  logic rate_cos;
  logic ie;

  assign ie = link.integration_epoch;
  assign adj_start = wr_in && (addr_in == `CRN_REG_SETTINGS);
  assign new_settings = wr_in && (addr_in == `CRN_REG_SW_RATE);

  // Register writes
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_adjust_value <= `CRN_ZERO32;
      phase_adjust_repeat_count <= `CRN_ZERO22;
      phase_adjust_timing <= `CRN_TIMING_IMMEDIATE;
      time_multiplex_enable <= 1'b0;
      subcarrier_pattern <= 2'h0;
    end else if (wr_in) begin
      unique case (addr_in)
        `CRN_REG_ADJUST: phase_adjust_value <= wdata_in;
        `CRN_REG_SETTINGS: begin
          phase_adjust_repeat_count <= wdata_in[`CRN_STEPS_W-1:0];
          phase_adjust_timing <= wdata_in[`CRN_STEPS_W+`CRN_TIMING_W-1:`CRN_STEPS_W];
        end
        `CRN_REG_CODE_CTRL: begin
          time_multiplex_enable <= wdata_in[0];
          subcarrier_pattern <= wdata_in[2:1];
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // Software rate term, deferred or immediate
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      software_rate_term <= `CRN_ZERO32;
      pend_rate <= 1'b0;
      pend_rate_value <= `CRN_ZERO32;
    end else if (new_settings && phase_adjust_timing == `CRN_TIMING_IMMEDIATE) begin
      software_rate_term <= wdata_in;
      pend_rate <= 1'b0;
    end else if (new_settings) begin
      pend_rate <= 1'b1;
      pend_rate_value <= wdata_in;
    end else if (pend_rate && ie) begin
      software_rate_term <= pend_rate_value;
      pend_rate <= 1'b0;
    end
  end

  // Summed increment
  assign code_rate_increment = link.aided_rate_term + software_rate_term;

  // ==========================================
  // Adjustment sequencer
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= crn_pkg::CRN_IDLE;
      steps_left <= `CRN_ZERO22;
    end else if (adj_start && wdata_in[`CRN_STEPS_W-1:0] == `CRN_ZERO22) begin
      state <= crn_pkg::CRN_IDLE;
      steps_left <= `CRN_ZERO22;
    end else if (adj_start) begin
      if (wdata_in[`CRN_STEPS_W+`CRN_TIMING_W-1:`CRN_STEPS_W] == `CRN_TIMING_IMMEDIATE) begin
        state <= crn_pkg::CRN_APPLY;
        steps_left <= wdata_in[`CRN_STEPS_W-1:0];
      end else begin
        state <= crn_pkg::CRN_ARMED;
      end
    end else begin
      unique case (state)
        crn_pkg::CRN_IDLE: ;
        crn_pkg::CRN_ARMED: begin
          if (ie) begin
            state <= crn_pkg::CRN_APPLY;
            steps_left <= phase_adjust_repeat_count;
          end
        end
        crn_pkg::CRN_APPLY: begin
          if (steps_left == `CRN_ONE22) begin
            steps_left <= `CRN_ZERO22;
            // Repeat mode re-arms for next epoch
            state <= (phase_adjust_timing == `CRN_TIMING_REPEAT_IE) ? crn_pkg::CRN_ARMED : crn_pkg::CRN_IDLE;
          end else begin
            steps_left <= steps_left - `CRN_ONE22;
          end
        end
        default: state <= crn_pkg::CRN_IDLE;
      endcase
    end
  end

  // ==========================================
  // Accumulator and subcarrier pulses
  logic [32:0] next_acc;
  always_comb begin
    next_acc = {1'b0, acc} + {1'b0, code_rate_increment};
    if (state == crn_pkg::CRN_APPLY) begin
      next_acc = next_acc + {phase_adjust_value[31], phase_adjust_value};
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc <= `CRN_ZERO32;
      rate_sin <= 1'b0;
      rate_cos <= 1'b0;
      cos_armed <= 1'b0;
    end else begin
      acc <= next_acc[31:0];
      rate_sin <= next_acc[32] && (code_rate_increment != `CRN_ZERO32);
      rate_cos <= cos_armed && next_acc[`CRN_MSB] && !acc[`CRN_MSB];
      if (next_acc[32]) begin
        cos_armed <= 1'b1;
      end else if (next_acc[`CRN_MSB] && !acc[`CRN_MSB]) begin
        cos_armed <= 1'b0;
      end
    end
  end
  assign link.rate_sin = rate_sin;
  assign link.rate_cos = rate_cos;

  // ==========================================
  // Epoch phase capture
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_at_integration <= `CRN_ZERO32;
      phase_at_measurement <= `CRN_ZERO32;
    end else begin
      if (ie) begin
        phase_at_integration <= acc;
      end
      if (link.measurement_epoch) begin
        phase_at_measurement <= acc;
      end
    end
  end

  // ==========================================
  // Read port
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= `CRN_ZERO32;
    end else if (rd_in) begin
      unique case (addr_in)
        `CRN_REG_SW_RATE: rdata_out <= software_rate_term;
        `CRN_REG_ADJUST: rdata_out <= acc;
        `CRN_REG_SETTINGS: rdata_out <= {8'h00, phase_adjust_timing, phase_adjust_repeat_count};
        `CRN_REG_CODE_CTRL: rdata_out <= {29'h0000_0000, subcarrier_pattern, time_multiplex_enable};
        `CRN_REG_PHASE_IE: rdata_out <= phase_at_integration;
        `CRN_REG_PHASE_ME: rdata_out <= phase_at_measurement;
        `CRN_REG_STATUS: rdata_out <= {28'h000_0000, pend_rate, state};
        default: rdata_out <= `CRN_ZERO32;
      endcase
    end else begin
      rdata_out <= `CRN_ZERO32;
    end
  end

  // Code output stage
  crn_tdm_mux u_mux (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .time_multiplex_enable_in(time_multiplex_enable),
    .subcarrier_pattern_in(subcarrier_pattern),
    .rate_sin_in(rate_sin),
    .lfsr_chip_in(link.lfsr_chip),
    .primary_chip_in(link.primary_chip),
    .code_out1_out(link.code_out1),
    .code_out2_out(link.code_out2)
  );
endmodule

// ==== testbench/crn_chk.sv ====
`timescale 1ns/1ps
// ==========
// Link checker
module crn_chk #(
  parameter int EPOCH_PULSES = 16
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Link
  input wire logic [31:0] aided_rate_term_in,
  input wire logic rate_sin_in,
  input wire logic rate_cos_in,
  input wire logic integration_epoch_in
);
  logic seen;
  int cnt;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // Wrap seen since cosine, sine pulses since epoch
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seen <= 1'b0;
      cnt <= 0;
    end else begin
      if (rate_sin_in) seen <= 1'b1;
      else if (rate_cos_in) seen <= 1'b0;
      if (integration_epoch_in) cnt <= int'(rate_sin_in);
      else if (rate_sin_in) cnt <= cnt + 1;
    end
  end
  a_sin_cos_apart: assert property (!(rate_sin_in && rate_cos_in)) else $error("sine and cosine together");
  a_cos_after_wrap: assert property (rate_cos_in |-> seen) else $error("cosine without wrap");
  a_cos_single: assert property (rate_cos_in |=> !rate_cos_in) else $error("cosine too long");
  a_ie_count: assert property (integration_epoch_in |-> cnt == EPOCH_PULSES) else $error("epoch count");
  a_ie_no_late: assert property (cnt <= EPOCH_PULSES) else $error("epoch missed");
  a_ie_after_sin: assert property (integration_epoch_in |-> $past(rate_sin_in)) else $error("epoch no pulse");
  a_ie_single: assert property (integration_epoch_in |=> !integration_epoch_in) else $error("epoch too long");
  a_reset_quiet: assert property ($rose(resetn_in) && aided_rate_term_in == 32'h0000_0000 |-> !rate_sin_in [*3])
    else $error("pulse after reset");
endmodule

// ==== testbench/crn_rate_gen_test.sv ====
`timescale 1ns/1ps
`include "crn_params.svh"
// ==========
// Bench top
module crn_rate_gen_test;
  localparam int EP = 4;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic [31:0] aided = 32'h0000_0000;
  logic meas = 1'b0;
  logic lfsr = 1'b0;
  logic prim = 1'b1;
  logic o1, o2, ie_out;
  logic ie_prev = 1'b0;
  int cyc = 0;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [31:0] p0, p1, adj;
  int t0, t1;
  crn_link_if link ();
  crn_rate_gen u_crn_rate_gen (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link(link));
  crn_far_end #(.EPOCH_PULSES(EP)) u_crn_far_end (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .aided_rate_term_in(aided), .measure_req_in(meas), .lfsr_chip_in(lfsr), .primary_chip_in(prim),
    .code_out1_out(o1), .code_out2_out(o2), .integration_epoch_out(ie_out), .link(link));
  crn_chk #(.EPOCH_PULSES(EP)) u_crn_chk (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .aided_rate_term_in(link.aided_rate_term), .rate_sin_in(link.rate_sin), .rate_cos_in(link.rate_cos),
    .integration_epoch_in(link.integration_epoch));
  // Clock
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // Cycle count and watchdog
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    ie_prev <= link.integration_epoch;
    cmp("ie out", {31'h0, ie_prev}, {31'h0, ie_out});
    if (cyc > 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // Register port cycles
  task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [31:0] d, output int t);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
    t = cyc;
  endtask
  task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  // Model: phase advance between two reads
  task automatic chk_adv(input string w, input logic [31:0] inc, input int k);
    cmp(w, 32'(longint'(t1 - t0) * longint'(inc) + longint'(k) * longint'($signed(adj))), p1 - p0);
  endtask
  task automatic wait_ie();
    int i;
    i = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      i++;
    end while (link.integration_epoch !== 1'b1 && i < 200);
    cmp("ie wait", 32'h0000_0001, {31'h0, link.integration_epoch});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [31:0] v;
    int ones;
    void'($urandom(8833));
    repeat (8) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    adj = 32'h0000_0000;
    rd_reg(`CRN_REG_ADJUST, p0, t0);
    repeat (12) @(posedge clk_sys_in);
    rd_reg(`CRN_REG_ADJUST, p1, t1);
    chk_adv("idle", 32'h0000_0000, 0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      aided <= $urandom & 32'h3fff_ffff;
      v = $urandom & 32'h3fff_ffff;
      wr_reg(`CRN_REG_SW_RATE, v);
      rd_reg(`CRN_REG_ADJUST, p0, t0);
      repeat ($urandom_range(9)) @(posedge clk_sys_in);
      rd_reg(`CRN_REG_ADJUST, p1, t1);
      chk_adv("sum", aided + v, 0);
    end
    @(posedge clk_sys_in);
    aided <= 32'h1000_0000;
    wr_reg(`CRN_REG_SW_RATE, 32'h3000_0000);
    for (int i = 0; i < 3; i++) begin
      adj = i == 0 ? 32'hffff_fc18 : i == 1 ? 32'h0000_7fff : 32'hc000_0000;
      rd_reg(`CRN_REG_ADJUST, p0, t0);
      wr_reg(`CRN_REG_ADJUST, adj);
      wr_reg(`CRN_REG_SETTINGS, {8'h00, `CRN_TIMING_IMMEDIATE, 22'(2 * i + 1)});
      repeat (2 * i + 3) @(posedge clk_sys_in);
      rd_reg(`CRN_REG_ADJUST, p1, t1);
      chk_adv("adjust", 32'h4000_0000, 2 * i + 1);
    end
    adj = 32'h0000_0100;
    wr_reg(`CRN_REG_ADJUST, adj);
    wait_ie();
    repeat (4) @(posedge clk_sys_in);
    rd_reg(`CRN_REG_ADJUST, p0, t0);
    wr_reg(`CRN_REG_SETTINGS, {8'h00, `CRN_TIMING_NEXT_IE, 22'h00_0002});
    wr_reg(`CRN_REG_SW_RATE, 32'h1000_0000);
    rd_reg(`CRN_REG_ADJUST, p1, t1);
    chk_adv("deferred", 32'h4000_0000, 0);
    rd_reg(`CRN_REG_STATUS, v, t1);
    cmp("status pending", 32'h0000_000a, v);
    wait_ie();
    repeat (4) @(posedge clk_sys_in);
    rd_reg(`CRN_REG_ADJUST, p0, t0);
    repeat (5) @(posedge clk_sys_in);
    rd_reg(`CRN_REG_ADJUST, p1, t1);
    chk_adv("new rate", 32'h2000_0000, 0);
    adj = 32'h0000_0300;
    wr_reg(`CRN_REG_ADJUST, adj);
    wait_ie();
    repeat (4) @(posedge clk_sys_in);
    rd_reg(`CRN_REG_ADJUST, p0, t0);
    wr_reg(`CRN_REG_SETTINGS, {8'h00, `CRN_TIMING_REPEAT_IE, 22'h00_0003});
    repeat (3) wait_ie();
    repeat (6) @(posedge clk_sys_in);
    rd_reg(`CRN_REG_ADJUST, p1, t1);
    chk_adv("repeat", 32'h2000_0000, 9);
    p0 = p1;
    t0 = t1;
    wr_reg(`CRN_REG_SETTINGS, {8'h00, `CRN_TIMING_REPEAT_IE, 22'h00_0000});
    rd_reg(`CRN_REG_SETTINGS, v, t1);
    cmp("settings", {8'h00, `CRN_TIMING_REPEAT_IE, 22'h00_0000}, v);
    rd_reg(`CRN_REG_STATUS, v, t1);
    cmp("status idle", 32'h0000_0001, v);
    repeat (2) wait_ie();
    repeat (6) @(posedge clk_sys_in);
    rd_reg(`CRN_REG_ADJUST, p1, t1);
    chk_adv("stopped", 32'h2000_0000, 0);
    wait_ie();
    rd_reg(`CRN_REG_PHASE_IE, p0, t0);
    wait_ie();
    rd_reg(`CRN_REG_PHASE_IE, p1, t1);
    cmp("ie phase", p0, p1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys_in);
      meas <= 1'b1;
      @(posedge clk_sys_in);
      meas <= 1'b0;
      rd_reg(`CRN_REG_PHASE_ME, v, t0);
      if (i == 0) p0 = v;
      else p1 = v;
      repeat (7 * (1 - i)) @(posedge clk_sys_in);
    end
    t0 = 0;
    t1 = 11;
    chk_adv("me phase", 32'h2000_0000, 0);
    for (int pat = 0; pat < 5; pat++) begin
      @(posedge clk_sys_in);
      lfsr <= pat == 4;
      ones = 0;
      wr_reg(`CRN_REG_CODE_CTRL, {29'h0, 2'(pat), pat < 4});
      rd_reg(`CRN_REG_CODE_CTRL, v, t0);
      cmp("code ctrl", {29'h0, 2'(pat), pat < 4}, v);
      repeat (4) @(posedge clk_sys_in);
      for (int c = 0; c < 40; c++) begin
        @(posedge clk_sys_in);
        #1;
        ones += int'(o1);
        if (pat < 4) cmp("code2", {31'h0, pat[o1]}, {31'h0, o2});
        else cmp("normal", 32'h3, {30'h0, o1, o2});
      end
      if (pat < 4) cmp("interleave", 32'h1, {31'h0, ones > 8 && ones < 32});
    end
    report_and_stop();
  end
endmodule
